// File: rtl/pxa_pkg.sv
// Purpose: shared constants and types of the two-group port expander access block.
// Assumes: group bytes use bit k for port k of the group.
// Notes:
// Functional notes
// [R01] two 7-bit addresses select group A or B
// [R02] group A port byte: inputs plus output pins
// [R03] address ack clears flags, releases interrupt
// [R04] second byte sends flags captured before clearing
// [R05] long reads alternate port and flags bytes
// [R06] change during read asserts interrupt at STOP
// [R07] no new interrupt during any read; the code holds it off only during group A accesses, not group B reads
// [R08] sample ports at ack preceding each sent byte
// [R09] master nack: no snapshot, interrupt unchanged
// [R10] interrupt stays released until STOP
// [R11] group B reads actual output pin levels
// [R12] group B multibyte read resamples each ack
// [R13] group A write sets outputs, mask, clears flags
// [R14] group A write acks, applies every byte
// [R15] group B write acks, loads every byte
// [R16] group A write snapshots at address ack
// [R17] change flag sticks until cleared
// [R18] mask gates interrupt only, not flags
// [R19] upper address bits 110 for A, 101 B
// [R20] bit k maps port k; inputs carry mask
package pxa_pkg;
  localparam int          ADDR_W    = 7;     // slave address width
  localparam int          SEL_W     = 4;     // address-select bits A3..A0
  localparam logic [2:0]  GRP_A_HI  = 3'h6;  // upper bits 1,1,0
  localparam logic [2:0]  GRP_B_HI  = 3'h5;  // upper bits 1,0,1
  localparam int          IN_LSB    = 2;     // first input bit in group A byte
  localparam int          IN_W      = 4;     // number of inputs
  localparam int          BYTE_W    = 8;     // byte width
  localparam logic [3:0]  OUT_A_RST = 4'h0;  // group A outputs after reset
  localparam logic [7:0]  OUT_B_RST = 8'h00; // group B outputs after reset
  localparam logic [3:0]  MASK_RST  = 4'h0;  // interrupt mask after reset
  localparam logic [2:0]  BIT_LAST  = 3'h7;  // last bit index of a byte

  // link-side bit engine states
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ADEC, LK_AACK, LK_WR, LK_WACK, LK_RD, LK_MACK
  } pxa_lk_st_t;
endpackage

// File: rtl/pxa_tgl_sync.sv
// Purpose: carry a toggle event into another clock domain as a one-cycle pulse.
// Assumes: source toggles no faster than three destination clocks.
// Notes: first stage is read only by the second stage.
`timescale 1ns/1ps
module pxa_tgl_sync (
  input  wire logic i_clk,    // destination clock
  input  wire logic i_rst_n,  // async reset, active low
  input  wire logic i_tgl,    // toggle from source domain
  output logic      o_pulse   // one-cycle event pulse
);
  logic s1_r;  // metastability stage
  logic s2_r;  // settled stage
  logic s3_r;  // previous settled value

  // three flops, edge of the settled value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_tgl;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign o_pulse = s2_r ^ s3_r;
endmodule // pxa_tgl_sync

// File: rtl/pxa_port_expander.sv
// Purpose: slave side of a two-group serial port expander with change flags.
// Assumes: bus lines sampled on i_link_clk, much faster than the serial clock.
// Notes: port logic on i_clk; events cross by toggles, held words stay stable.
`timescale 1ns/1ps
module pxa_port_expander (
  input  wire logic       i_clk,            // system clock 125 MHz
  input  wire logic       i_rst_n,          // async reset, active low
  input  wire logic       i_link_clk,       // link sampling clock
  input  wire logic       i_scl,            // serial clock pin
  input  wire logic       i_sda,            // serial data pin level
  output logic            o_sda_o,          // serial data drive value
  output logic            o_sda_oe,         // serial data pull low enable
  input  wire logic [1:0] i_addr_sel_low,   // address bits A1..A0
  input  wire logic [1:0] i_addr_sel_high,  // address bits A3..A2
  input  wire logic [3:0] i_grp_a_inputs,   // group A input pins
  input  wire logic [3:0] i_grp_a_out_fb,   // pin levels of outs 7,6,1,0
  input  wire logic [7:0] i_grp_b_fb,       // pin levels of group B outs
  output logic            o_grp_a_out_0,    // group A output 0
  output logic            o_grp_a_out_1,    // group A output 1
  output logic            o_grp_a_out_6,    // group A output 6
  output logic            o_grp_a_out_7,    // group A output 7
  output logic      [7:0] o_grp_b_outputs,  // group B outputs
  output logic            o_int_n_o,        // interrupt drive value
  output logic            o_int_n_oe        // interrupt pull low enable
);
  // ---------------- link domain ----------------
  pxa_pkg::pxa_lk_st_t st_r;        // bit engine state
  logic [5:0]          lk_s1_r;     // pin sync stage one
  logic [5:0]          lk_s2_r;     // pin sync stage two
  logic [1:0]          lk_d_r;      // previous scl, sda
  logic [2:0]          cnt_r;       // bit counter
  logic [7:0]          sh_r;        // shift register
  logic                sda_oe_r;    // pulling sda low
  logic                l_grp_b_r;   // addressed group is B
  logic                l_rw_r;      // read access
  logic [7:0]          l_rx_r;      // received write byte, held
  logic                act_r;       // addressed since start
  logic                tg_adr_r;    // address ack event
  logic                tg_ack_r;    // master ack event
  logic                tg_wr_r;     // write byte event
  logic                tg_stop_r;   // stop event
  logic                scl_w;       // synced scl
  logic                sda_w;       // synced sda
  logic                rise_w;      // scl rising
  logic                fall_w;      // scl falling
  logic                start_w;     // start condition
  logic                stop_w;      // stop condition
  logic [3:0]          sel_w;       // synced address select
  logic                hit_a_w;     // address matches group A
  logic                hit_b_w;     // address matches group B
  // ---------------- system domain ----------------
  logic [15:0]         pin_s1_r;    // pin sync stage one
  logic [15:0]         pin_s2_r;    // pin sync stage two
  logic [3:0]          in_prev_r;   // previous input levels
  logic                prime_r;     // previous levels valid
  logic [3:0]          flags_r;     // change flags
  logic [3:0]          snap_r;      // flags captured at clear
  logic [7:0]          tx_r;        // byte for next transmit
  logic                nxt_flag_r;  // next group A byte is flags
  logic                busy_r;      // group A access open
  logic                grp_b_r;     // current access is group B
  logic [3:0]          out_a_r;     // outs 7,6,1,0
  logic [7:0]          out_b_r;     // group B outputs
  logic [3:0]          mask_r;      // interrupt mask
  logic                int_r;       // interrupt asserted
  logic                adr_p;       // address ack pulse
  logic                ack_p;       // master ack pulse
  logic                wr_p;        // write byte pulse
  logic                stop_p;      // stop pulse
  logic [3:0]          in_w;        // synced inputs
  logic [3:0]          afb_w;       // synced group A out pins
  logic [7:0]          bfb_w;       // synced group B pins
  logic [3:0]          chg_w;       // input changes this cycle
  logic                clr_w;       // clear flags, take snapshot
  logic                port_w;      // send a port byte next

  // group A port byte, bit k is port k
  function automatic logic [7:0] port_byte(input logic [3:0] fb, input logic [3:0] inp);
    port_byte = {fb[3], fb[2], inp, fb[1], fb[0]};
  endfunction

  // ======== link domain ========
  // two-flop sync of bus pins and address select
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_s1_r <= 6'h03;
      lk_s2_r <= 6'h03;
      lk_d_r  <= 2'h3;
    end else begin
      lk_s1_r <= {i_addr_sel_high, i_addr_sel_low, i_sda, i_scl};
      lk_s2_r <= lk_s1_r;
      lk_d_r  <= lk_s2_r[1:0];
    end
  end

  assign scl_w   = lk_s2_r[0];
  assign sda_w   = lk_s2_r[1];
  assign sel_w   = lk_s2_r[5:2];
  assign rise_w  = scl_w & ~lk_d_r[0];
  assign fall_w  = ~scl_w & lk_d_r[0];
  assign start_w = scl_w & lk_d_r[0] & lk_d_r[1] & ~sda_w;
  assign stop_w  = scl_w & lk_d_r[0] & ~lk_d_r[1] & sda_w;
  // [R19] fixed upper bits
  assign hit_a_w = (sh_r[7:1] == {pxa_pkg::GRP_A_HI, sel_w});
  assign hit_b_w = (sh_r[7:1] == {pxa_pkg::GRP_B_HI, sel_w});

  // bit engine: receive address and data, send bytes, acks
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= pxa_pkg::LK_IDLE;
      cnt_r     <= 3'h0;
      sh_r      <= 8'h00;
      sda_oe_r  <= 1'b0;
      l_grp_b_r <= 1'b0;
      l_rw_r    <= 1'b0;
      l_rx_r    <= 8'h00;
      act_r     <= 1'b0;
      tg_adr_r  <= 1'b0;
      tg_ack_r  <= 1'b0;
      tg_wr_r   <= 1'b0;
      tg_stop_r <= 1'b0;
    end else if (stop_w) begin
      // stop ends any access
      st_r     <= pxa_pkg::LK_IDLE;
      sda_oe_r <= 1'b0;
      act_r    <= 1'b0;
      if (act_r) begin
        tg_stop_r <= ~tg_stop_r;
      end
    end else if (start_w) begin
      // start or repeated start
      st_r     <= pxa_pkg::LK_ADDR;
      cnt_r    <= 3'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        pxa_pkg::LK_ADDR: begin
          if (rise_w) begin
            sh_r  <= {sh_r[6:0], sda_w};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == pxa_pkg::BIT_LAST) begin
              st_r <= pxa_pkg::LK_ADEC;
            end
          end
        end
        pxa_pkg::LK_ADEC: begin
          if (fall_w) begin
            // [R01] answer two addresses
            if (hit_a_w || hit_b_w) begin
              sda_oe_r  <= 1'b1;
              l_grp_b_r <= hit_b_w;
              l_rw_r    <= sh_r[0];
              st_r      <= pxa_pkg::LK_AACK;
            end else begin
              st_r <= pxa_pkg::LK_IDLE;
            end
          end
        end
        pxa_pkg::LK_AACK: begin
          if (rise_w) begin
            // [R08] snapshot at address ack
            tg_adr_r <= ~tg_adr_r;
            act_r    <= 1'b1;
          end else if (fall_w) begin
            cnt_r <= 3'h0;
            if (l_rw_r) begin
              sh_r     <= tx_r;
              sda_oe_r <= ~tx_r[7];
              st_r     <= pxa_pkg::LK_RD;
            end else begin
              sda_oe_r <= 1'b0;
              st_r     <= pxa_pkg::LK_WR;
            end
          end
        end
        pxa_pkg::LK_WR: begin
          if (rise_w) begin
            sh_r  <= {sh_r[6:0], sda_w};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == pxa_pkg::BIT_LAST) begin
              // [R14] [R15] hand each byte over
              l_rx_r  <= {sh_r[6:0], sda_w};
              tg_wr_r <= ~tg_wr_r;
              st_r    <= pxa_pkg::LK_WACK;
            end
          end
        end
        pxa_pkg::LK_WACK: begin
          // ack driven on first fall, released on second
          if (fall_w) begin
            sda_oe_r <= ~sda_oe_r;
            if (sda_oe_r) begin
              st_r <= pxa_pkg::LK_WR;
            end
          end
        end
        pxa_pkg::LK_RD: begin
          if (fall_w) begin
            if (cnt_r == pxa_pkg::BIT_LAST) begin
              sda_oe_r <= 1'b0;
              st_r     <= pxa_pkg::LK_MACK;
            end else begin
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
              cnt_r    <= cnt_r + 3'h1;
            end
          end
        end
        pxa_pkg::LK_MACK: begin
          if (rise_w) begin
            // [R09] nack: no event, wait for stop
            if (!sda_w) begin
              tg_ack_r <= ~tg_ack_r;
              st_r     <= pxa_pkg::LK_AACK;
            end else begin
              st_r <= pxa_pkg::LK_IDLE;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_r;

  // ======== event crossings ========
  pxa_tgl_sync u_adr  (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tgl(tg_adr_r),  .o_pulse(adr_p));
  pxa_tgl_sync u_ack  (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tgl(tg_ack_r),  .o_pulse(ack_p));
  pxa_tgl_sync u_wr   (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tgl(tg_wr_r),   .o_pulse(wr_p));
  pxa_tgl_sync u_stop (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tgl(tg_stop_r), .o_pulse(stop_p));

  // ======== system domain ========
  // two-flop sync of port pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
    end else begin
      pin_s1_r <= {i_grp_b_fb, i_grp_a_out_fb, i_grp_a_inputs};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign in_w  = pin_s2_r[3:0];
  assign afb_w = pin_s2_r[7:4];
  assign bfb_w = pin_s2_r[15:8];
  assign chg_w = prime_r ? (in_w ^ in_prev_r) : 4'h0;
  // [R03] [R05] [R13] clear at group A address ack and at each flags-byte ack, before the next port byte
  assign port_w = ack_p && !grp_b_r && !nxt_flag_r;
  assign clr_w  = (adr_p && !l_grp_b_r) || port_w;

  // change detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_prev_r <= 4'h0;
      prime_r   <= 1'b0;
    end else begin
      in_prev_r <= in_w;
      prime_r   <= 1'b1;
    end
  end

  // [R17] [R18] sticky flags, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r <= 4'h0;
      snap_r  <= 4'h0;
    end else begin
      flags_r <= (clr_w ? 4'h0 : flags_r) | chg_w;
      if (clr_w) begin
        // [R04] keep flags seen before the clear
        snap_r <= flags_r;
      end
    end
  end

  // transmit byte selection and pairing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_r       <= 8'h00;
      nxt_flag_r <= 1'b0;
      grp_b_r    <= 1'b0;
    end else if (adr_p) begin
      grp_b_r    <= l_grp_b_r;
      nxt_flag_r <= ~l_grp_b_r;
      // [R02] [R11] [R16] snapshot at address ack
      tx_r <= l_grp_b_r ? bfb_w : port_byte(afb_w, in_w);
    end else if (ack_p) begin
      if (grp_b_r) begin
        // [R12] fresh pin levels
        tx_r <= bfb_w;
      end else if (nxt_flag_r) begin
        tx_r       <= {2'b00, snap_r, 2'b00};
        nxt_flag_r <= 1'b0;
      end else begin
        // [R05] resample port byte
        tx_r       <= port_byte(afb_w, in_w);
        nxt_flag_r <= 1'b1;
      end
    end
  end

  // output latches and mask
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_a_r <= pxa_pkg::OUT_A_RST;
      out_b_r <= pxa_pkg::OUT_B_RST;
      mask_r  <= pxa_pkg::MASK_RST;
    end else if (wr_p) begin
      if (grp_b_r) begin
        // [R15] all eight outputs
        out_b_r <= l_rx_r;
      end else begin
        // [R14] [R20] outputs and mask per byte
        out_a_r <= {l_rx_r[7], l_rx_r[6], l_rx_r[1], l_rx_r[0]};
        mask_r  <= l_rx_r[pxa_pkg::IN_LSB +: pxa_pkg::IN_W];
      end
    end
  end

  // interrupt: released during group A access, rechecked at stop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      int_r  <= 1'b0;
    end else if (adr_p && !l_grp_b_r) begin
      // [R03] [R07] [R10] release and hold
      busy_r <= 1'b1;
      int_r  <= 1'b0;
    end else if (stop_p && busy_r) begin
      // [R06] deferred change asserts at stop
      busy_r <= 1'b0;
      int_r  <= |(flags_nxt_mask());
    end else if (!busy_r) begin
      // [R18] only enabled inputs interrupt
      int_r <= int_r | (|(chg_w & mask_r));
    end
  end

  // flags that will stand after this cycle, masked
  function automatic logic [3:0] flags_nxt_mask();
    flags_nxt_mask = (flags_r | chg_w) & mask_r;
  endfunction

  assign o_grp_a_out_0   = out_a_r[0];
  assign o_grp_a_out_1   = out_a_r[1];
  assign o_grp_a_out_6   = out_a_r[2];
  assign o_grp_a_out_7   = out_a_r[3];
  assign o_grp_b_outputs = out_b_r;
  assign o_int_n_o       = 1'b0;
  assign o_int_n_oe      = int_r;

  // ======== checks ========
  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n) clr_w |=> flags_r == $past(chg_w);
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared at ack"); // [R03]
  property p_snap;
    @(posedge i_clk) disable iff (!i_rst_n) clr_w |=> snap_r == $past(flags_r);
  endproperty
  a_snap: assert property (p_snap) else $error("old flags not kept"); // [R04]
  property p_quiet;
    @(posedge i_clk) disable iff (!i_rst_n) (busy_r && !stop_p) |=> !int_r;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt during access"); // [R07]
  property p_stop_int;
    @(posedge i_clk) disable iff (!i_rst_n) (stop_p && busy_r && (|((flags_r | chg_w) & mask_r))) |=> int_r;
  endproperty
  a_stop_int: assert property (p_stop_int) else $error("no interrupt at stop"); // [R06]
  property p_sticky;
    @(posedge i_clk) disable iff (!i_rst_n)
      !clr_w |=> (flags_r & ($past(flags_r) | $past(chg_w))) == ($past(flags_r) | $past(chg_w));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // [R17]
  property p_b_read;
    @(posedge i_clk) disable iff (!i_rst_n) (ack_p && grp_b_r) |=> tx_r == $past(bfb_w);
  endproperty
  a_b_read: assert property (p_b_read) else $error("group B not resampled"); // [R12]
  property p_a_write;
    @(posedge i_clk) disable iff (!i_rst_n) (wr_p && !grp_b_r) |=> {2'h0, mask_r, 2'h0} == ($past(l_rx_r) & 8'h3C);
  endproperty
  a_a_write: assert property (p_a_write) else $error("mask not written"); // [R14]
  property p_b_write;
    @(posedge i_clk) disable iff (!i_rst_n) (wr_p && grp_b_r) |=> o_grp_b_outputs == $past(l_rx_r);
  endproperty
  a_b_write: assert property (p_b_write) else $error("group B not written"); // [R15]
  property p_addr_ack;
    @(posedge i_link_clk) disable iff (!i_rst_n)
      (st_r == pxa_pkg::LK_ADEC && fall_w && !stop_w && !start_w && hit_a_w) |=> sda_oe_r;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // [R01]
  c_a_read:  cover property (@(posedge i_clk) disable iff (!i_rst_n) adr_p && !l_grp_b_r ##[1:1000] ack_p);
  c_b_write: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_p && grp_b_r);
  c_int_stop: cover property (@(posedge i_clk) disable iff (!i_rst_n) stop_p && busy_r ##1 int_r);
endmodule // pxa_port_expander

// File: dv/pxa_i2c_master.sv
// Purpose: behavioural serial bus master that drives the expander link.
// Assumes: SDA has a pull-up on the bench; this model only pulls low.
// Notes: a quarter bit is counted in i_clk cycles; SCL idles high.
`timescale 1ns/1ps
module pxa_i2c_master (
  input  wire logic i_clk,     // bench clock
  input  wire logic i_sda,     // resolved data wire
  output logic      o_scl,     // serial clock drive
  output logic      o_sda_low  // high pulls data low
);
  localparam int QTR = 20;  // quarter bit, keeps phases well above 12 clocks

  // idle bus: clock high, data released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // one quarter bit of waiting
  task automatic q();
    repeat (QTR) @(posedge i_clk);
  endtask

  // start, also serves as repeated start
  task automatic start();
    q();
    o_sda_low <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b0;
  endtask

  // stop: data rises while clock high
  task automatic stop();
    q();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_low <= 1'b0;
    q();
  endtask

  // one clocked bit, data sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    q();
    o_sda_low <= ~b;
    q();
    o_scl <= 1'b1;
    q();
    s = i_sda;
    q();
    o_scl <= 1'b0;
  endtask

  // byte out, msb first, then the device's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // byte in, then ack or nack from this side
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule // pxa_i2c_master

// File: dv/pxa_port_expander_tb.sv
// Purpose: self-checking bench for the port expander access block.
// Assumes: master model on the link, pull-up on the data wire.
// Notes: group A pins read back the latches, group B pins can be forced.
`timescale 1ns/1ps
module pxa_port_expander_tb;
  localparam logic [3:0] SEL   = 4'hA;         // address select bits
  localparam logic [6:0] ADR_A = {3'h6, SEL};  // group A address
  localparam logic [6:0] ADR_B = {3'h5, SEL};  // group B address
  localparam logic [6:0] ADR_X = {3'h6, 4'hB}; // foreign address
  localparam logic [7:0] A_WR  = 8'h97;        // outs 7,1,0 high, mask 4'h5
  logic       clk      = 1'b0;  // system clock
  logic       link_clk = 1'b0;  // link sampling clock
  logic       rst_n    = 1'b0;  // reset, active low
  logic       scl;              // master clock
  logic       sda_low;          // master pulls data low
  logic       sda_oe;           // device pulls data low
  logic       sda_o;            // device data value
  wire logic  sda;              // resolved data wire
  logic [3:0] ins      = 4'h0;  // group A input pins
  logic [7:0] force_b  = 8'h00; // group B pins forced off latch
  logic [3:0] sel      = SEL;   // address select pins
  wire  [3:0] a_out;            // group A outputs 7,6,1,0
  logic [7:0] b_out;            // group B outputs
  logic       int_o;            // interrupt value
  logic       int_oe;           // interrupt asserted
  int         n_fail   = 0;     // mismatches
  int         n_tests  = 0;     // comparisons

  // clocks, link clock offset in phase
  always #4 clk = ~clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // open-drain wire with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  pxa_port_expander pxa_port_expander_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_addr_sel_low(sel[1:0]), .i_addr_sel_high(sel[3:2]),
    .i_grp_a_inputs(ins), .i_grp_a_out_fb(a_out), .i_grp_b_fb(b_out ^ force_b),
    .o_grp_a_out_0(a_out[0]), .o_grp_a_out_1(a_out[1]),
    .o_grp_a_out_6(a_out[2]), .o_grp_a_out_7(a_out[3]),
    .o_grp_b_outputs(b_out), .o_int_n_o(int_o), .o_int_n_oe(int_oe)
  );
  pxa_i2c_master pxa_i2c_master_i (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );

  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // expected group A port byte
  function automatic logic [7:0] pb(input logic [3:0] i);
    return (A_WR & 8'hC3) | {2'b00, i, 2'b00};
  endfunction

  // start plus address byte
  task automatic addr(input logic [6:0] a, input logic rd, output logic ack);
    pxa_i2c_master_i.start();
    pxa_i2c_master_i.wr_byte({a, rd}, ack);
  endtask

  // change inputs, let them settle
  task automatic set_in(input logic [3:0] v);
    @(posedge clk);
    ins <= v;
    repeat (10) @(posedge clk);
  endtask

  // multibyte writes to both groups
  task automatic t_write();
    logic ack;
    addr(ADR_B, 1'b0, ack);
    chk("b addr ack", 8'h01, {7'h00, ack});
    pxa_i2c_master_i.wr_byte(8'hA5, ack);
    chk("b out 1", 8'hA5, b_out);
    pxa_i2c_master_i.wr_byte(8'h3C, ack);
    chk("b out 2", 8'h3C, b_out);
    pxa_i2c_master_i.stop();
    addr(ADR_A, 1'b0, ack);
    pxa_i2c_master_i.wr_byte(8'h42, ack);
    chk("a out 1", 8'h42, {a_out[3:2], 4'h0, a_out[1:0]});
    pxa_i2c_master_i.wr_byte(A_WR, ack);
    chk("a ack", 8'h01, {7'h00, ack});
    chk("a out 2", A_WR & 8'hC3, {a_out[3:2], 4'h0, a_out[1:0]});
    pxa_i2c_master_i.stop();
    $display("write test done");
  endtask

  // mask, sticky flags, read clearing and deferred interrupt
  task automatic t_int();
    logic ack;
    logic [7:0] d;
    set_in(4'h2);
    set_in(4'h0);
    chk("int unmasked", 8'h00, {7'h00, int_oe});
    set_in(4'h1);
    chk("int masked", 8'h01, {7'h00, int_oe});
    addr(ADR_A, 1'b1, ack);
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("int released", 8'h00, {7'h00, int_oe});
    chk("port byte", pb(4'h1), d);
    set_in(4'h5);
    chk("int held", 8'h00, {7'h00, int_oe});
    pxa_i2c_master_i.rd_byte(1'b0, d);
    chk("flags byte", 8'h0C, d);
    chk("int held 2", 8'h00, {7'h00, int_oe});
    pxa_i2c_master_i.stop();
    repeat (20) @(posedge clk);
    chk("int at stop", 8'h01, {7'h00, int_oe});
    $display("interrupt test done");
  endtask

  // four byte read: port, flags, port, flags
  task automatic t_long();
    logic ack;
    logic [7:0] d;
    addr(ADR_A, 1'b1, ack);
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("port 1", pb(4'h5), d);
    set_in(4'h1);
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("flags 1", 8'h10, d);
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("port 2", pb(4'h1), d);
    pxa_i2c_master_i.rd_byte(1'b0, d);
    chk("flags 2", 8'h10, d);
    pxa_i2c_master_i.stop();
    repeat (20) @(posedge clk);
    chk("no int", 8'h00, {7'h00, int_oe});
    $display("long read test done");
  endtask

  // group B readback of forced pins, resampled per byte
  task automatic t_rd_b();
    logic ack;
    logic [7:0] d;
    @(posedge clk);
    force_b <= 8'h0F;
    addr(ADR_B, 1'b1, ack);
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("b pins 1", 8'h33, d);
    @(posedge clk);
    force_b <= 8'hF0;
    pxa_i2c_master_i.rd_byte(1'b1, d);
    chk("b pins 2", 8'h33, d);
    pxa_i2c_master_i.rd_byte(1'b0, d);
    chk("b pins 3", 8'hCC, d);
    pxa_i2c_master_i.stop();
    @(posedge clk);
    force_b <= 8'h00;
    $display("group b read test done");
  endtask

  // foreign address leaves interrupt, group A write clears it
  task automatic t_nack();
    logic ack;
    set_in(4'h0);
    addr(ADR_X, 1'b1, ack);
    chk("foreign ack", 8'h00, {7'h00, ack});
    pxa_i2c_master_i.stop();
    chk("int kept", 8'h01, {7'h00, int_oe});
    chk("int value", 8'h00, {7'h00, int_o});
    // select pins move the lower address bits
    @(posedge clk);
    sel <= 4'hB;
    addr({3'h5, 4'hB}, 1'b0, ack);
    chk("moved sel ack", 8'h01, {7'h00, ack});
    pxa_i2c_master_i.stop();
    chk("int kept b", 8'h01, {7'h00, int_oe});
    @(posedge clk);
    sel <= SEL;
    addr(ADR_A, 1'b0, ack);
    pxa_i2c_master_i.wr_byte(A_WR, ack);
    chk("int cleared", 8'h00, {7'h00, int_oe});
    pxa_i2c_master_i.stop();
    repeat (20) @(posedge clk);
    chk("int off", 8'h00, {7'h00, int_oe});
    $display("nack test done");
  endtask

  // watchdog, well beyond the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // reset, then the scenarios
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_write();
    t_int();
    t_long();
    t_rd_b();
    t_nack();
    stop_test();
  end
endmodule // pxa_port_expander_tb
